/* hdl/wdlp_top.sv */
// Summary of operation
// RULE1: Lost reference clock selects limp clock output; the code enters it only while pllActive is high, then holds it until the reference returns.
// RULE2: Limp entry latches pending NMI request.
// RULE3: Reset select: immediate reset or NMI counter.
// RULE4: Limp entry sets sticky missing-clock status.
// RULE5: NMI counter runs only while fail latched.
// RULE6: 8-bit watchdog fires at maximum unless disabled.
// RULE7: Counter cleared only by 0x55 then 0xAA.
// RULE8: Watchdog reset pulse low 512 cycles.
// RULE9: Watchdog counter frozen in limp mode.
// RULE10: Standby keeps watchdog running, wakes device.
// RULE11: Watchdog interrupt brings CPU out of idle.
// RULE12: Watchdog expiry in halt resets device.
// RULE13: Code 00 idle, all clocks run.
// RULE14: Code 01 standby, only oscillator runs.
// RULE15: Code 1X halt, all clocks stop.
// RULE16: Wake inputs active low, else stay asleep.
// RULE17: Standby wake inputs selected and qualified.
// RULE18: Halt wake input taken from select register.
// RULE19: Low-power modes never touch output pins.
// RULE20: Debug port clock keeps running always.
// RULE21: Halt refused unless watchdog clock enabled.
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module wdlp_top #(
  parameter int WD_PRESCALE = wdlp_pkg::WD_PRESCALE_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic refClkPresent,
  input wire logic pllActive,
  input wire logic idleExec,
  input wire logic anyIrqPending,
  input wire logic [31:0] gpioWakeN,
  input wire logic debugWakeN,
  output logic limpClockSelect,
  output logic clockFailureFlag,
  output logic nmiRequest,
  output logic deviceResetN,
  output logic watchdogResetOutN,
  output logic watchdogWakeIrqN,
  output logic cpuClockRun,
  output logic systemClockRun,
  output logic oscillatorClockRun,
  output logic tapClockRun
);
  wd_link_if wdLink();

  logic ack_r;
  logic [31:0] rdData_r;
  logic wbReq;
  logic wbWrite;
  logic [4:0] regOfs;

  logic [2:0] wdCtrl_r;
  logic [7:0] lowPowerControl_r;
  logic [31:0] wakeInputSelect_r;
  logic nmiResetSelect_r;
  logic [15:0] nmiPeriod_r;
  logic [15:0] nmiCnt_r;
  logic missingClockStatus_r;
  logic clkFailLatched_r;
  logic haltRefused_r;

  logic refSync1_r;
  logic refSync2_r;
  logic [31:0] gpioSync1_r;
  logic [31:0] gpioSync2_r;
  logic dbgSync1_r;
  logic dbgSync2_r;

  logic limp_r;
  logic limpEntry;
  logic nmiReset;
  logic [$clog2(wdlp_pkg::NMI_RST_CYCLES+1)-1:0] nmiRstCnt_r;

  wdlp_pkg::lp_state_t lpState_r;
  wdlp_pkg::lp_state_t lpState_nxt;
  logic [wdlp_pkg::LP_QUAL_W-1:0] qualCnt_r;
  logic selectedLow;
  logic gpioQualified;
  logic wdIrqSeen;
  logic clearMissing;
  logic clearFail;

  function automatic logic wordWrite(input logic [4:0] ofs, input logic [4:0] target);
    wordWrite = (ofs == target);
  endfunction

  // Pins from outside this clock are synchronised before use
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      refSync1_r <= 1'b1;
      refSync2_r <= 1'b1;
      gpioSync1_r <= '1;
      gpioSync2_r <= '1;
      dbgSync1_r <= 1'b1;
      dbgSync2_r <= 1'b1;
    end else begin
      refSync1_r <= refClkPresent;
      refSync2_r <= refSync1_r;
      gpioSync1_r <= gpioWakeN;
      gpioSync2_r <= gpioSync1_r;
      dbgSync1_r <= debugWakeN;
      dbgSync2_r <= dbgSync1_r;
    end
  end

  // Wishbone slave: one wait state, ack dropped the cycle after
  assign wbReq = wb_cyc_i && wb_stb_i && !ack_r;
  assign wbWrite = wbReq && wb_we_i;
  assign regOfs = {wb_adr_i[4:2], 2'b00};

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wbReq;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdData_r <= '0;
    end else if (wbReq) begin
      unique case (regOfs)
        wdlp_pkg::OFS_WD_CTRL: rdData_r <= {29'h0, wdCtrl_r};
        wdlp_pkg::OFS_WD_KEY: rdData_r <= {24'h0, wdLink.count};
        wdlp_pkg::OFS_LP_CTRL: rdData_r <= {24'h0, lowPowerControl_r};
        wdlp_pkg::OFS_WAKE_SEL: rdData_r <= wakeInputSelect_r;
        wdlp_pkg::OFS_NMI_CFG: rdData_r <= {nmiPeriod_r, 15'h0, nmiResetSelect_r};
        wdlp_pkg::OFS_STATUS: rdData_r <= {26'h0, lpState_r, haltRefused_r, limp_r,
                                           clkFailLatched_r, missingClockStatus_r};
        wdlp_pkg::OFS_NMI_CNT: rdData_r <= {16'h0, nmiCnt_r};
        default: rdData_r <= '0;
      endcase
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdData_r;

  // Configuration registers, low byte lane for narrow fields
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wdCtrl_r <= wdlp_pkg::WD_CTRL_RESET;
      lowPowerControl_r <= wdlp_pkg::LP_CTRL_RESET;
      wakeInputSelect_r <= '0;
      nmiResetSelect_r <= 1'b0;
      nmiPeriod_r <= wdlp_pkg::NMI_PERIOD_RESET;
    end else if (wbWrite) begin
      if (wordWrite(regOfs, wdlp_pkg::OFS_WD_CTRL) && wb_sel_i[0]) begin
        wdCtrl_r <= wb_dat_i[2:0];
      end
      if (wordWrite(regOfs, wdlp_pkg::OFS_LP_CTRL) && wb_sel_i[0]) begin
        lowPowerControl_r <= wb_dat_i[7:0];
      end
      if (wordWrite(regOfs, wdlp_pkg::OFS_WAKE_SEL)) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            wakeInputSelect_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8]; // RULE17
          end
        end
      end
      if (wordWrite(regOfs, wdlp_pkg::OFS_NMI_CFG)) begin
        if (wb_sel_i[0]) begin
          nmiResetSelect_r <= wb_dat_i[wdlp_pkg::NMI_CFG_RST_SEL];
        end
        if (wb_sel_i[2]) begin
          nmiPeriod_r[7:0] <= wb_dat_i[23:16];
        end
        if (wb_sel_i[3]) begin
          nmiPeriod_r[15:8] <= wb_dat_i[31:24];
        end
      end
    end
  end

  // Clock loss detection; the limp clock is switched in by the clock tree
  assign limpEntry = pllActive && !refSync2_r && !limp_r;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      limp_r <= 1'b0;
    end else if (limpEntry) begin
      limp_r <= 1'b1; // RULE1
    end else if (refSync2_r) begin
      limp_r <= 1'b0;
    end
  end

  assign limpClockSelect = limp_r; // RULE1
  assign clockFailureFlag = limpEntry;

  assign clearMissing = wbWrite && wordWrite(regOfs, wdlp_pkg::OFS_STATUS) && wb_sel_i[0]
                        && wb_dat_i[wdlp_pkg::ST_MISSING_CLK];
  assign clearFail = wbWrite && wordWrite(regOfs, wdlp_pkg::OFS_STATUS) && wb_sel_i[0]
                     && wb_dat_i[wdlp_pkg::ST_CLK_FAIL];

  // Sticky flags, write one to clear; a new failure wins over the clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      missingClockStatus_r <= 1'b0;
      clkFailLatched_r <= 1'b0;
    end else begin
      if (limpEntry) begin
        missingClockStatus_r <= 1'b1; // RULE4
        clkFailLatched_r <= 1'b1; // RULE2
      end else begin
        if (clearMissing) begin
          missingClockStatus_r <= 1'b0;
        end
        if (clearFail) begin
          clkFailLatched_r <= 1'b0;
        end
      end
    end
  end

  assign nmiRequest = clkFailLatched_r; // RULE2

  // NMI watchdog counts only while the failure is pending
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      nmiCnt_r <= '0;
    end else if (!clkFailLatched_r || nmiResetSelect_r || nmiReset) begin
      nmiCnt_r <= '0; // RULE5
    end else begin
      nmiCnt_r <= nmiCnt_r + 16'h0001; // RULE5
    end
  end

  assign nmiReset = (limpEntry && nmiResetSelect_r) // RULE3
                    || (clkFailLatched_r && !nmiResetSelect_r && nmiCnt_r == nmiPeriod_r); // RULE3

  // Device reset pulse for the NMI path, one cycle wider than the watchdog one
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      nmiRstCnt_r <= '0;
    end else if (nmiReset && nmiRstCnt_r == '0) begin
      nmiRstCnt_r <= ($clog2(wdlp_pkg::NMI_RST_CYCLES+1))'(wdlp_pkg::NMI_RST_CYCLES);
    end else if (nmiRstCnt_r != '0) begin
      nmiRstCnt_r <= nmiRstCnt_r - 1'b1;
    end
  end

  // CPU watchdog hookup
  assign wdLink.counterDisable = wdCtrl_r[wdlp_pkg::WD_CTRL_DISABLE]; // RULE6
  assign wdLink.freeze = limp_r || !wdCtrl_r[wdlp_pkg::WD_CTRL_CLK_EN]; // RULE9
  // Halt has no running CPU to take an interrupt, so expiry must reset
  assign wdLink.irqMode = wdCtrl_r[wdlp_pkg::WD_CTRL_IRQ_MODE] && lpState_r != wdlp_pkg::LP_HALT; // RULE12
  assign wdLink.keyStrobe = wbWrite && wordWrite(regOfs, wdlp_pkg::OFS_WD_KEY) && wb_sel_i[0]; // RULE7
  assign wdLink.keyData = wb_dat_i[7:0];

  cpu_watchdog #(
    .PRESCALE(WD_PRESCALE),
    .PULSE(wdlp_pkg::WD_PULSE_CYCLES)
  ) u_wdog (
    .core_clk(core_clk),
    .nrst(nrst),
    .link(wdLink)
  );

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      watchdogResetOutN <= 1'b1;
      watchdogWakeIrqN <= 1'b1;
      deviceResetN <= 1'b1;
    end else begin
      watchdogResetOutN <= !wdLink.resetActive; // RULE8
      watchdogWakeIrqN <= !wdLink.irqActive; // RULE10
      deviceResetN <= !(wdLink.resetActive || nmiRstCnt_r != '0 || nmiReset); // RULE12
    end
  end

  // Wake qualification on the selected port inputs, active low
  assign selectedLow = |(~gpioSync2_r & wakeInputSelect_r); // RULE16 RULE18
  assign gpioQualified = selectedLow
                         && qualCnt_r == lowPowerControl_r[wdlp_pkg::LP_QUAL_LSB +: wdlp_pkg::LP_QUAL_W];
  assign wdIrqSeen = wdLink.irqActive;

  // A short low restarts the count, so the device stays asleep
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      qualCnt_r <= '0;
    end else if (!selectedLow || lpState_r == wdlp_pkg::LP_RUN || gpioQualified) begin
      qualCnt_r <= '0; // RULE16
    end else begin
      qualCnt_r <= qualCnt_r + 1'b1; // RULE17
    end
  end

  always_comb begin
    lpState_nxt = lpState_r;
    unique case (lpState_r)
      wdlp_pkg::LP_RUN: begin
        if (idleExec) begin
          if (lowPowerControl_r[wdlp_pkg::LP_CODE_HALT_BIT]) begin
            if (wdCtrl_r[wdlp_pkg::WD_CTRL_CLK_EN]) begin // RULE21
              lpState_nxt = wdlp_pkg::LP_HALT; // RULE15
            end
          end else if (lowPowerControl_r[1:0] == wdlp_pkg::LP_CODE_STANDBY) begin
            lpState_nxt = wdlp_pkg::LP_STANDBY; // RULE14
          end else begin
            lpState_nxt = wdlp_pkg::LP_IDLE; // RULE13
          end
        end
      end
      wdlp_pkg::LP_IDLE: begin
        if (anyIrqPending || wdIrqSeen) begin // RULE11 RULE13
          lpState_nxt = wdlp_pkg::LP_RUN;
        end
      end
      wdlp_pkg::LP_STANDBY: begin
        if (wdIrqSeen || gpioQualified || !dbgSync2_r) begin // RULE10 RULE14 RULE17
          lpState_nxt = wdlp_pkg::LP_RUN;
        end
      end
      wdlp_pkg::LP_HALT: begin
        if (gpioQualified || !dbgSync2_r) begin // RULE15 RULE18
          lpState_nxt = wdlp_pkg::LP_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lpState_r <= wdlp_pkg::LP_RUN;
    end else if (!deviceResetN) begin
      lpState_r <= wdlp_pkg::LP_RUN; // RULE12
    end else begin
      lpState_r <= lpState_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      haltRefused_r <= 1'b0;
    end else if (lpState_r == wdlp_pkg::LP_RUN && idleExec
                 && lowPowerControl_r[wdlp_pkg::LP_CODE_HALT_BIT]
                 && !wdCtrl_r[wdlp_pkg::WD_CTRL_CLK_EN]) begin
      haltRefused_r <= 1'b1; // RULE21
    end else if (clearMissing && wb_dat_i[wdlp_pkg::ST_HALT_REFUSED]) begin
      haltRefused_r <= 1'b0;
    end
  end

  // Clock enables only; pin output levels are left to their owners
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cpuClockRun <= 1'b1;
      systemClockRun <= 1'b1;
      oscillatorClockRun <= 1'b1;
    end else begin
      cpuClockRun <= lpState_nxt inside {wdlp_pkg::LP_RUN, wdlp_pkg::LP_IDLE}; // RULE13 RULE14 RULE19
      systemClockRun <= lpState_nxt inside {wdlp_pkg::LP_RUN, wdlp_pkg::LP_IDLE}; // RULE13 RULE14
      oscillatorClockRun <= lpState_nxt != wdlp_pkg::LP_HALT; // RULE10 RULE15
    end
  end

  assign tapClockRun = 1'b1; // RULE20
endmodule
`default_nettype wire

/* hdl/wdlp_pkg.sv */
package wdlp_pkg;

  // Register byte offsets on the bus
  localparam logic [4:0] OFS_WD_CTRL = 5'h00;
  localparam logic [4:0] OFS_WD_KEY = 5'h04;
  localparam logic [4:0] OFS_LP_CTRL = 5'h08;
  localparam logic [4:0] OFS_WAKE_SEL = 5'h0C;
  localparam logic [4:0] OFS_NMI_CFG = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [4:0] OFS_NMI_CNT = 5'h18;

  // Watchdog control fields
  localparam int WD_CTRL_DISABLE = 0;
  localparam int WD_CTRL_IRQ_MODE = 1;
  localparam int WD_CTRL_CLK_EN = 2;
  localparam logic [2:0] WD_CTRL_RESET = 3'h4;

  // Low-power control fields
  localparam int LP_MODE_LSB = 0;
  localparam int LP_QUAL_LSB = 2;
  localparam int LP_QUAL_W = 6;
  localparam logic [7:0] LP_CTRL_RESET = 8'h00;
  localparam logic [1:0] LP_CODE_IDLE = 2'h0;
  localparam logic [1:0] LP_CODE_STANDBY = 2'h1;
  localparam int LP_CODE_HALT_BIT = 1;

  // NMI configuration fields
  localparam int NMI_CFG_RST_SEL = 0;
  localparam int NMI_CFG_PERIOD_LSB = 16;
  localparam logic [15:0] NMI_PERIOD_RESET = 16'h0FFF;

  // Status fields
  localparam int ST_MISSING_CLK = 0;
  localparam int ST_CLK_FAIL = 1;
  localparam int ST_LIMP = 2;
  localparam int ST_HALT_REFUSED = 3;
  localparam int ST_LP_STATE_LSB = 4;

  // Watchdog figures
  localparam logic [7:0] WD_KEY_FIRST = 8'h55;
  localparam logic [7:0] WD_KEY_SECOND = 8'hAA;
  localparam logic [7:0] WD_COUNT_MAX = 8'hFF;
  localparam int WD_PULSE_CYCLES = 512;
  localparam int WD_PRESCALE_CYCLES = 512;
  localparam int NMI_RST_CYCLES = 512;

  typedef enum logic [1:0] {LP_RUN, LP_IDLE, LP_STANDBY, LP_HALT} lp_state_t;

endpackage

/* hdl/wd_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface wd_link_if;
  logic counterDisable;
  logic freeze;
  logic irqMode;
  logic keyStrobe;
  logic [7:0] keyData;
  logic [7:0] count;
  logic expire;
  logic resetActive;
  logic irqActive;
  modport ctrl(output counterDisable, freeze, irqMode, keyStrobe, keyData,
               input count, expire, resetActive, irqActive);
  modport wdog(input counterDisable, freeze, irqMode, keyStrobe, keyData,
               output count, expire, resetActive, irqActive);
endinterface
`default_nettype wire

/* hdl/cpu_watchdog.sv */
`timescale 1ns/1ns
`default_nettype none
module cpu_watchdog #(
  parameter int PRESCALE = wdlp_pkg::WD_PRESCALE_CYCLES,
  parameter int PULSE = wdlp_pkg::WD_PULSE_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  wd_link_if.wdog link
);
  logic [$clog2(PRESCALE)-1:0] preCnt_r;
  logic [$clog2(PULSE+1)-1:0] pulseCnt_r;
  logic keyArmed_r;
  logic tick;

  assign tick = (preCnt_r == ($clog2(PRESCALE))'(PRESCALE - 1));

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      preCnt_r <= '0;
    end else if (tick) begin
      preCnt_r <= '0;
    end else begin
      preCnt_r <= preCnt_r + 1'b1;
    end
  end

  // Key pair must arrive in order; any other byte breaks the pair
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      keyArmed_r <= 1'b0;
    end else if (link.keyStrobe) begin
      keyArmed_r <= (link.keyData == wdlp_pkg::WD_KEY_FIRST); // RULE7
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      link.count <= '0;
      link.expire <= 1'b0;
    end else begin
      link.expire <= 1'b0;
      if (link.keyStrobe && keyArmed_r && link.keyData == wdlp_pkg::WD_KEY_SECOND) begin
        link.count <= '0; // RULE7
      end else if (link.counterDisable) begin
        link.count <= '0;
      end else if (tick && !link.freeze) begin // RULE9
        if (link.count == wdlp_pkg::WD_COUNT_MAX) begin
          link.expire <= 1'b1; // RULE6
          link.count <= '0;
        end else begin
          link.count <= link.count + 8'h01;
        end
      end
    end
  end

  // Expiry pulse, either reset or wake request, fixed width
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pulseCnt_r <= '0;
      link.resetActive <= 1'b0;
      link.irqActive <= 1'b0;
    end else if (link.expire && pulseCnt_r == '0) begin
      pulseCnt_r <= ($clog2(PULSE+1))'(PULSE - 1);
      link.resetActive <= !link.irqMode; // RULE8
      link.irqActive <= link.irqMode;
    end else if (pulseCnt_r != '0) begin
      pulseCnt_r <= pulseCnt_r - 1'b1;
    end else begin
      link.resetActive <= 1'b0;
      link.irqActive <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* bench/wdlp_top_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module wdlp_top_asserts (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic pllActive,
  input wire logic idleExec,
  input wire logic limpClockSelect,
  input wire logic clockFailureFlag,
  input wire logic nmiRequest,
  input wire logic deviceResetN,
  input wire logic watchdogResetOutN,
  input wire logic watchdogWakeIrqN,
  input wire logic cpuClockRun,
  input wire logic systemClockRun,
  input wire logic oscillatorClockRun,
  input wire logic tapClockRun
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [9:0] rstLow_r;
  logic [9:0] irqLow_r;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstLow_r <= 10'h000;
      irqLow_r <= 10'h000;
    end else begin
      rstLow_r <= watchdogResetOutN ? 10'h000 : rstLow_r + 10'h001;
      irqLow_r <= watchdogWakeIrqN ? 10'h000 : irqLow_r + 10'h001;
    end
  end
  sequence limp_entry;
    clockFailureFlag && pllActive;
  endsequence
  sequence nmi_raised;
    limpClockSelect && nmiRequest;
  endsequence
  a_limp_entry: assert property (limp_entry |=> nmi_raised)
    else $error("limp entry");
  a_fail_needs_pll: assert property (clockFailureFlag |-> pllActive)
    else $error("fail without pll");
  a_nmi_sticky: assert property ($fell(nmiRequest) |-> (wb_ack_o && wb_we_i) || !deviceResetN)
    else $error("nmi dropped");
  a_reset_width: assert property ($rose(watchdogResetOutN) |-> rstLow_r == 10'h200)
    else $error("reset width");
  a_irq_width: assert property ($rose(watchdogWakeIrqN) |-> irqLow_r == 10'h200)
    else $error("wake width");
  a_expiry_resets: assert property ($fell(watchdogResetOutN) |=> !deviceResetN)
    else $error("no device reset");
  a_clocks_paired: assert property (cpuClockRun == systemClockRun)
    else $error("clock enables differ");
  a_osc_halt: assert property (!oscillatorClockRun |-> !cpuClockRun)
    else $error("cpu clock in halt");
  a_sleep_cause: assert property ($fell(cpuClockRun) |-> $past(idleExec))
    else $error("sleep without idle");
  a_tap_alive: assert property (tapClockRun)
    else $error("debug clock stopped");
endmodule
bind wdlp_top wdlp_top_asserts chk_u (.core_clk(core_clk), .nrst(nrst), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .pllActive(pllActive), .idleExec(idleExec), .limpClockSelect(limpClockSelect),
  .clockFailureFlag(clockFailureFlag), .nmiRequest(nmiRequest), .deviceResetN(deviceResetN),
  .watchdogResetOutN(watchdogResetOutN), .watchdogWakeIrqN(watchdogWakeIrqN), .cpuClockRun(cpuClockRun),
  .systemClockRun(systemClockRun), .oscillatorClockRun(oscillatorClockRun), .tapClockRun(tapClockRun));
`default_nettype wire

/* bench/cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cpu_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic idleReq,
  input wire logic extIrq,
  input wire logic watchdogWakeIrqN,
  output logic idleExec,
  output logic anyIrqPending
);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) idleExec <= 1'b0;
    else idleExec <= idleReq && !idleExec;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) anyIrqPending <= 1'b0;
    else anyIrqPending <= extIrq || !watchdogWakeIrqN;
  end
endmodule
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic core_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, refClkPresent, pllActive, idleExec;
  logic anyIrqPending, debugWakeN, idleReq, extIrq, limpClockSelect, clockFailureFlag, nmiRequest;
  logic deviceResetN, watchdogResetOutN, watchdogWakeIrqN, cpuClockRun, systemClockRun;
  logic oscillatorClockRun, tapClockRun;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, gpioWakeN, rd, c;
  logic [3:0] wb_sel_i;
  int nErrors = 0;
  int checked = 0;
  localparam logic [4:0] KEY = wdlp_pkg::OFS_WD_KEY;
  localparam logic [4:0] CTL = wdlp_pkg::OFS_WD_CTRL;
  localparam logic [4:0] ST = wdlp_pkg::OFS_STATUS;
  wdlp_top #(.WD_PRESCALE(8)) dut_u (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .refClkPresent(refClkPresent), .pllActive(pllActive),
    .idleExec(idleExec), .anyIrqPending(anyIrqPending), .gpioWakeN(gpioWakeN), .debugWakeN(debugWakeN),
    .limpClockSelect(limpClockSelect), .clockFailureFlag(clockFailureFlag), .nmiRequest(nmiRequest),
    .deviceResetN(deviceResetN), .watchdogResetOutN(watchdogResetOutN), .watchdogWakeIrqN(watchdogWakeIrqN),
    .cpuClockRun(cpuClockRun), .systemClockRun(systemClockRun), .oscillatorClockRun(oscillatorClockRun),
    .tapClockRun(tapClockRun));
  cpu_model cpu_u (.core_clk(core_clk), .nrst(nrst), .idleReq(idleReq), .extIrq(extIrq),
    .watchdogWakeIrqN(watchdogWakeIrqN), .idleExec(idleExec), .anyIrqPending(anyIrqPending));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      nErrors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return watchdogResetOutN;
      1: return watchdogWakeIrqN;
      2: return cpuClockRun;
      3: return deviceResetN;
      default: return limpClockSelect;
    endcase
  endfunction
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= s;
    wb_adr_i <= {27'h0000000, a};
    wb_dat_i <= d;
    do @(posedge core_clk);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wt(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= lim) chk($sformatf("wait %0d", s), v, pick(s));
  endtask
  task automatic width(input int s);
    int w;
    w = 0;
    while (pick(s) === 1'b0 && w < 600) begin
      @(posedge core_clk);
      w++;
    end
    chk("pulse width", wdlp_pkg::WD_PULSE_CYCLES, w);
  endtask
  task automatic idle();
    @(posedge core_clk);
    idleReq <= 1'b1;
    @(posedge core_clk);
    idleReq <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic gp(input logic [31:0] v, input int n);
    @(posedge core_clk);
    gpioWakeN <= v;
    repeat (n) @(posedge core_clk);
    gpioWakeN <= 32'hFFFFFFFF;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic kick();
    wb(1, KEY, 32'h55);
    wb(1, KEY, 32'hAA);
  endtask
  task automatic test_regs();
    wb(0, CTL, 0);
    chk("wd ctrl reset", 32'h4, rd);
    wb(0, wdlp_pkg::OFS_NMI_CFG, 0);
    chk("nmi cfg reset", 32'h0FFF0000, rd);
    wb(0, wdlp_pkg::OFS_LP_CTRL, 0);
    chk("lp ctrl reset", 32'h0, rd);
    wb(1, wdlp_pkg::OFS_WAKE_SEL, 32'h12345678, 4'h0);
    wb(0, wdlp_pkg::OFS_WAKE_SEL, 0);
    chk("wake sel no lanes", 32'h0, rd);
    wb(1, 5'h1C, 32'hFFFFFFFF);
    wb(0, 5'h1C, 0);
    chk("unmapped read", 32'h0, rd);
    wb(1, CTL, 32'h5);
    $display("test_regs done");
  endtask
  task automatic test_key();
    kick();
    wb(1, CTL, 32'h4);
    repeat (100) @(posedge core_clk);
    wb(0, KEY, 0);
    c = rd;
    chk("counting", 1, c >= 11 && c <= 15);
    wb(1, KEY, 32'h55);
    wb(1, KEY, 32'h12);
    wb(1, KEY, 32'hAA);
    wb(0, KEY, 0);
    chk("broken pair", 1, rd >= c);
    kick();
    wb(0, KEY, 0);
    chk("pair clears", 1, rd <= 1);
    $display("test_key done");
  endtask
  task automatic test_expire();
    kick();
    wt(0, 0, 2300);
    width(0);
    wb(1, CTL, 32'h6);
    kick();
    wb(1, wdlp_pkg::OFS_LP_CTRL, 0);
    idle();
    wb(0, ST, 0);
    chk("idle state", 2'h1, rd[5:4]);
    chk("idle cpu clock", 1, cpuClockRun);
    wt(1, 0, 2300);
    width(1);
    wb(0, ST, 0);
    chk("idle wd exit", 2'h0, rd[5:4]);
    idle();
    @(posedge core_clk);
    extIrq <= 1'b1;
    repeat (4) @(posedge core_clk);
    extIrq <= 1'b0;
    wb(0, ST, 0);
    chk("idle irq exit", 2'h0, rd[5:4]);
    wb(1, wdlp_pkg::OFS_LP_CTRL, 32'h2);
    idle();
    wt(0, 0, 2300);
    wt(0, 1, 600);
    wb(1, CTL, 32'h5);
    $display("test_expire done");
  endtask
  task automatic test_sleep();
    wb(1, wdlp_pkg::OFS_LP_CTRL, 32'hD);
    wb(1, wdlp_pkg::OFS_WAKE_SEL, 32'h20);
    idle();
    chk("standby clocks", 3'h1, {cpuClockRun, systemClockRun, oscillatorClockRun});
    gp(32'hFFFFFFEF, 20);
    chk("unselected pin", 0, cpuClockRun);
    gp(32'hFFFFFFDF, 2);
    chk("short low", 0, cpuClockRun);
    gp(32'hFFFFFFDF, 12);
    chk("gpio wake", 1, cpuClockRun);
    idle();
    @(posedge core_clk);
    debugWakeN <= 1'b0;
    wt(2, 1, 8);
    debugWakeN <= 1'b1;
    wb(1, CTL, 32'h1);
    wb(1, wdlp_pkg::OFS_LP_CTRL, 32'hE);
    idle();
    chk("halt refused", 1, cpuClockRun);
    wb(0, ST, 0);
    chk("refused flag", 1, rd[3]);
    wb(1, CTL, 32'h5);
    idle();
    chk("halt clocks", 2'h0, {oscillatorClockRun, cpuClockRun});
    gp(32'hFFFFFFDF, 12);
    chk("halt gpio wake", 1, cpuClockRun);
    $display("test_sleep done");
  endtask
  task automatic test_fail();
    kick();
    wb(1, CTL, 32'h4);
    @(posedge core_clk);
    pllActive <= 1'b0;
    refClkPresent <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk("no pll no limp", 0, limpClockSelect);
    refClkPresent <= 1'b1;
    pllActive <= 1'b1;
    repeat (4) @(posedge core_clk);
    refClkPresent <= 1'b0;
    wt(4, 1, 6);
    wb(0, ST, 0);
    chk("fail status", 3'h7, rd[2:0]);
    wb(0, KEY, 0);
    c = rd;
    repeat (100) @(posedge core_clk);
    wb(0, KEY, 0);
    chk("wd frozen", c, rd);
    wb(1, CTL, 32'h5);
    wb(0, wdlp_pkg::OFS_NMI_CNT, 0);
    c = rd;
    wb(0, wdlp_pkg::OFS_NMI_CNT, 0);
    chk("nmi counting", 1, rd > c);
    wb(1, ST, 32'h3);
    wb(0, wdlp_pkg::OFS_NMI_CNT, 0);
    chk("nmi count cleared", 0, rd);
    chk("nmi cleared", 0, nmiRequest);
    @(posedge core_clk);
    refClkPresent <= 1'b1;
    wt(4, 0, 6);
    wb(1, wdlp_pkg::OFS_NMI_CFG, 32'h00200000);
    refClkPresent <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk("reset waits period", 1, deviceResetN);
    wt(3, 0, 30);
    wt(3, 1, 600);
    wb(1, ST, 32'h3);
    wb(1, wdlp_pkg::OFS_NMI_CFG, 32'h00200001);
    refClkPresent <= 1'b1;
    wt(4, 0, 6);
    @(posedge core_clk);
    refClkPresent <= 1'b0;
    wt(3, 0, 6);
    wt(3, 1, 600);
    wb(1, ST, 32'h3);
    refClkPresent <= 1'b1;
    $display("test_fail done");
  endtask
  initial begin
    nrst = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, idleReq, extIrq} = 5'h00;
    {refClkPresent, pllActive, debugWakeN} = 3'h7;
    wb_sel_i = 4'hF;
    wb_adr_i = 32'h00000000;
    wb_dat_i = 32'h00000000;
    gpioWakeN = 32'hFFFFFFFF;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    test_regs();
    test_key();
    test_expire();
    test_sleep();
    test_fail();
    report_and_stop();
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    nErrors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
